// ---- design/gdl_pkg.sv ----
/*
  Shared constants for the global data link configuration block:
  register offsets, field positions, reset values, limits and enumerations.
  Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
*/
package gdl_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_FAULT_ID = 8'h04;
  localparam logic [7:0] OFF_LEGACY   = 8'h08;
  localparam logic [7:0] OFF_STATBASE = 8'h0c;
  localparam logic [7:0] OFF_MSG      = 8'h10;
  localparam logic [7:0] OFF_STATE    = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_SBN_LSB = 0;
  localparam int unsigned CTRL_SBN_W   = 5;
  localparam int unsigned CTRL_RATE_LSB = 8;
  localparam int unsigned CTRL_POL_BIT = 12;
  localparam int unsigned CTRL_FRE_BIT = 16;
  localparam int unsigned CTRL_GO_BIT  = 31;

  // Message register fields
  localparam int unsigned MSG_LEN_LSB  = 0;
  localparam int unsigned MSG_LEN_W    = 11;
  localparam int unsigned MSG_KIND_BIT = 12;
  localparam int unsigned MSG_SKIP_LSB = 16;

  // State register fields
  localparam int unsigned ST_CONF_BIT  = 0;
  localparam int unsigned ST_ERR_BIT   = 1;
  localparam int unsigned ST_HOST_BIT  = 2;
  localparam int unsigned ST_LINK_BIT  = 3;
  localparam int unsigned ST_RATE_LSB  = 8;

  typedef enum logic [1:0] {
    GDL_RATE_STD  = 2'b00,
    GDL_RATE_EXT  = 2'b01,
    GDL_RATE_R768 = 2'b10,
    GDL_RATE_R384 = 2'b11
  } gdl_rate_e;

  typedef enum logic {
    GDL_FILL_ZERO = 1'b0,
    GDL_FILL_HOLD = 1'b1
  } gdl_policy_e;

  typedef enum logic {
    GDL_MEM_BIT  = 1'b0,
    GDL_MEM_WORD = 1'b1
  } gdl_mem_e;

  // Reset values and limits
  localparam logic [4:0]  SBN_RST        = 5'h10;
  localparam logic [4:0]  SBN_MAX_SLOW   = 5'h0f;
  localparam logic [7:0]  FID_RST        = 8'h21;
  localparam logic [7:0]  FID_MIN        = 8'h10;
  localparam logic [7:0]  FID_MAX        = 8'hfe;
  localparam logic [15:0] LEGACY_MAX     = 16'h3fff;
  localparam logic [15:0] STATBASE_RST   = 16'h0001;
  localparam logic [10:0] LEN_WORD_MAX   = 11'h040;
  localparam logic [10:0] LEN_BIT_MAX    = 11'h400;
  localparam logic [7:0]  SKIP_MAX       = 8'h80;
  localparam logic [11:0] MSG_BYTES      = 12'h080;

  // Interrupt bits
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_CFG_ERR  = 0;
  localparam int unsigned IRQ_HOST_OFF = 1;
  localparam int unsigned IRQ_STN_LOST = 2;
  localparam int unsigned IRQ_RX       = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam int unsigned STATIONS = 32;

endpackage : gdl_pkg

// ---- design/gdl_subst.sv ----
/*
  Loss substitution stage for one 32-bit data word.
  Assumes live and load come from logic on the same clock.
*/
`timescale 1ns/1ps
module gdl_subst
  import gdl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        live,
  input  wire logic        load,
  input  wire logic [31:0] din,
  input  wire gdl_policy_e policy,
  output logic [31:0]      dout
);

  typedef struct packed {
    logic [31:0] last;
    logic [31:0] out;
  } gdl_subst_s;

  gdl_subst_s st_reg;
  gdl_subst_s st_next;

  always_comb begin
    st_next = st_reg;
    if (live && load) begin
      st_next.last = din;
      st_next.out  = din;
    end else if (!live) begin
      // Last valid word or zeros once the source is lost
      st_next.out = (policy == GDL_FILL_HOLD) ? st_reg.last : 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.out;

endmodule : gdl_subst

// ---- design/gdl_top.sv ----
/*
  Global data link configuration bank: AXI4-Lite registers holding station
  number, link rate, fault report settings, legacy base, status base and
  message layout, plus outgoing and incoming loss substitution.
  Assumes link-side inputs (scan tick, receive stream, presence map, host
  liveness) come from logic on aclk.
*/
`timescale 1ns/1ps
// Operation
// - Station number is 0..31 and resets to 16.
// - Link rate offers standard, extended, 76.8 and 38.4 kbaud, equal on every station.
// - Rate resets to 153.6 kbaud standard.
// - At 38.4 kbaud only stations 0..15 may be used.
// - One policy, resetting to zero fill, selects hold-last or zeros on loss.
// - Outgoing data is substituted when the host stops servicing the block.
// - Incoming data of missing stations is substituted before the host sees it.
// - The same policy serves both directions.
// - A 32-bit status word is published with a base that resets to the first point.
// - Legacy base accepts 1..16383, zero disabling delivery; the code only stores the value for read-back.
// - Fault reporting resets off and its station ID is 16..254, resetting to 33.
// - Length is 0..64 words or 0..1024 bits, zero meaning no exchange.
// - Skip bytes are 0..128 and skip plus length stays within the message.
// - A message maps to one memory kind only.
// - Nothing is exchanged until configuration is complete.
// - Transmission continues each scan while the host is stopped.
module gdl_top
  import gdl_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               host_alive,
  input  wire logic               host_tx_load,
  input  wire logic [31:0]        host_tx_data,
  input  wire logic               scan_tick,
  output logic                    bus_tx_valid,
  output logic [31:0]             bus_tx_data,
  input  wire logic               rx_valid,
  input  wire logic [4:0]         rx_station,
  input  wire logic [31:0]        rx_data,
  input  wire logic [31:0]        station_present,
  input  wire logic [4:0]         host_rx_station,
  output logic [31:0]             host_rx_data,
  output logic                    link_enable,
  output logic [31:0]             status_word,
  output logic [15:0]             status_base,
  output logic                    irq
);

  typedef struct packed {
    logic                   aw_got;
    logic                   w_got;
    logic [ADDR_W-1:0]      aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [4:0]             sbn;
    gdl_rate_e              rate;
    gdl_policy_e            policy;
    logic                   fre;
    logic [7:0]             fid;
    logic [15:0]            legacy;
    logic [15:0]            stat_base;
    logic [10:0]            len;
    gdl_mem_e               kind;
    logic [7:0]             skip;
    logic                   configured;
    logic                   cfg_err;
    logic [IRQ_W-1:0]       irq_stat;
    logic [IRQ_W-1:0]       irq_en;
    logic                   host_alive_d;
    logic [31:0]            present_d;
    logic [STATIONS-1:0][31:0] rx_mem;
    logic [31:0]            host_rx;
    logic                   tx_valid;
  } gdl_state_s;

  gdl_state_s st_reg;
  gdl_state_s st_next;
  logic [31:0] tx_word;

  // Byte-lane merge of a write onto a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Message size in bytes for the given kind and length
  function automatic logic [11:0] msg_bytes(input gdl_mem_e kind, input logic [10:0] len);
    logic [11:0] r;
    r = (kind == GDL_MEM_WORD) ? {len, 1'b0} : 12'({len + 11'h007} >> 3);
    return r;
  endfunction : msg_bytes

  function automatic logic [31:0] ctrl_word(input gdl_state_s s);
    logic [31:0] r;
    r = '0;
    r[CTRL_SBN_LSB +: CTRL_SBN_W] = s.sbn;
    r[CTRL_RATE_LSB +: 2] = s.rate;
    r[CTRL_POL_BIT] = s.policy;
    r[CTRL_FRE_BIT] = s.fre;
    r[CTRL_GO_BIT] = s.configured;
    return r;
  endfunction : ctrl_word

  function automatic logic [31:0] msg_word(input gdl_state_s s);
    logic [31:0] r;
    r = '0;
    r[MSG_LEN_LSB +: MSG_LEN_W] = s.len;
    r[MSG_KIND_BIT] = s.kind;
    r[MSG_SKIP_LSB +: 8] = s.skip;
    return r;
  endfunction : msg_word

  logic [31:0]      wv;
  logic             do_write;
  logic             wr_bad;
  logic             wr_unmapped;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [4:0]       n_sbn;
  gdl_rate_e        n_rate;
  logic [10:0]      n_len;
  gdl_mem_e         n_kind;
  logic [7:0]       n_skip;
  logic             exch;

  always_comb begin
    st_next     = st_reg;
    wv          = '0;
    wr_bad      = 1'b0;
    wr_unmapped = 1'b0;
    irq_set     = '0;
    irq_clr     = '0;
    n_sbn       = st_reg.sbn;
    n_rate      = st_reg.rate;
    n_len       = st_reg.len;
    n_kind      = st_reg.kind;
    n_skip      = st_reg.skip;
    exch        = st_reg.configured && (st_reg.len != 11'h000);

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

    if (do_write) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      unique case (st_reg.aw_addr)
        OFF_CTRL: begin
          wv     = merge(ctrl_word(st_reg), st_reg.w_data, st_reg.w_strb);
          n_sbn  = wv[CTRL_SBN_LSB +: CTRL_SBN_W];
          n_rate = gdl_rate_e'(wv[CTRL_RATE_LSB +: 2]);
          wr_bad = (n_rate == GDL_RATE_R384) && (n_sbn > SBN_MAX_SLOW);
          if (!wr_bad) begin
            st_next.sbn        = n_sbn;
            st_next.rate       = n_rate;
            st_next.policy     = gdl_policy_e'(wv[CTRL_POL_BIT]);
            st_next.fre        = wv[CTRL_FRE_BIT];
            st_next.configured = wv[CTRL_GO_BIT];
          end
        end
        OFF_FAULT_ID: begin
          wv     = merge({24'h000000, st_reg.fid}, st_reg.w_data, st_reg.w_strb);
          wr_bad = (wv[31:8] != 24'h000000) || (wv[7:0] < FID_MIN) || (wv[7:0] > FID_MAX);
          if (!wr_bad) begin
            st_next.fid = wv[7:0];
          end
        end
        OFF_LEGACY: begin
          wv     = merge({16'h0000, st_reg.legacy}, st_reg.w_data, st_reg.w_strb);
          wr_bad = (wv[31:16] != 16'h0000) || (wv[15:0] > LEGACY_MAX);
          if (!wr_bad) begin
            st_next.legacy = wv[15:0];
          end
        end
        OFF_STATBASE: begin
          wv     = merge({16'h0000, st_reg.stat_base}, st_reg.w_data, st_reg.w_strb);
          wr_bad = (wv[31:16] != 16'h0000);
          if (!wr_bad) begin
            st_next.stat_base = wv[15:0];
          end
        end
        OFF_MSG: begin
          wv     = merge(msg_word(st_reg), st_reg.w_data, st_reg.w_strb);
          n_len  = wv[MSG_LEN_LSB +: MSG_LEN_W];
          n_kind = gdl_mem_e'(wv[MSG_KIND_BIT]);
          n_skip = wv[MSG_SKIP_LSB +: 8];
          wr_bad = ((n_kind == GDL_MEM_WORD) ? (n_len > LEN_WORD_MAX)
                                              : (n_len > LEN_BIT_MAX))
                   || (n_skip > SKIP_MAX)
                   || ({4'h0, n_skip} + msg_bytes(n_kind, n_len) > MSG_BYTES);
          if (!wr_bad) begin
            st_next.len  = n_len;
            st_next.kind = n_kind;
            st_next.skip = n_skip;
          end
        end
        OFF_IRQ_EN: begin
          wv             = merge({28'h0000000, st_reg.irq_en}, st_reg.w_data, st_reg.w_strb);
          st_next.irq_en = wv[IRQ_W-1:0];
        end
        OFF_IRQ_CLR: begin
          irq_clr = st_reg.w_data[IRQ_W-1:0] & {IRQ_W{st_reg.w_strb[0]}};
        end
        OFF_STATE, OFF_IRQ_STAT: begin
          wr_unmapped = 1'b0;
        end
        default: begin
          wr_unmapped = 1'b1;
        end
      endcase
      st_next.bresp = (wr_bad || wr_unmapped) ? RESP_SLVERR : RESP_OKAY;
      if (wr_bad) begin
        st_next.cfg_err     = 1'b1;
        irq_set[IRQ_CFG_ERR] = 1'b1;
      end
    end

    // Read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL:     st_next.rdata = ctrl_word(st_reg);
        OFF_FAULT_ID: st_next.rdata = {24'h000000, st_reg.fid};
        OFF_LEGACY:   st_next.rdata = {16'h0000, st_reg.legacy};
        OFF_STATBASE: st_next.rdata = {16'h0000, st_reg.stat_base};
        OFF_MSG:      st_next.rdata = msg_word(st_reg);
        OFF_STATE:    st_next.rdata = status_word;
        OFF_IRQ_STAT: st_next.rdata = {28'h0000000, st_reg.irq_stat};
        OFF_IRQ_EN:   st_next.rdata = {28'h0000000, st_reg.irq_en};
        OFF_IRQ_CLR:  st_next.rdata = 32'h0000_0000;
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Incoming path: store per station, substitute for missing ones
    st_next.present_d    = station_present;
    st_next.host_alive_d = host_alive;
    if (exch && rx_valid) begin
      st_next.rx_mem[rx_station] = rx_data;
      irq_set[IRQ_RX]            = 1'b1;
    end
    if (!exch) begin
      st_next.host_rx = 32'h0000_0000;
    end else if (station_present[host_rx_station]) begin
      st_next.host_rx = st_reg.rx_mem[host_rx_station];
    end else begin
      st_next.host_rx = (st_reg.policy == GDL_FILL_HOLD)
                      ? st_reg.rx_mem[host_rx_station] : 32'h0000_0000;
    end
    if (|(st_reg.present_d & ~station_present)) begin
      irq_set[IRQ_STN_LOST] = 1'b1;
    end
    if (st_reg.host_alive_d && !host_alive) begin
      irq_set[IRQ_HOST_OFF] = 1'b1;
    end

    // One word out per scan, host alive or not
    st_next.tx_valid = exch && scan_tick;

    // Set wins over clear
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg           <= '0;
      st_reg.sbn       <= SBN_RST;
      st_reg.rate      <= GDL_RATE_STD;
      st_reg.policy    <= GDL_FILL_ZERO;
      st_reg.fid       <= FID_RST;
      st_reg.stat_base <= STATBASE_RST;
      st_reg.kind      <= GDL_MEM_WORD;
    end else begin
      st_reg <= st_next;
    end
  end

  gdl_subst u_tx_subst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .live    (host_alive),
    .load    (host_tx_load && st_reg.configured),
    .din     (host_tx_data),
    .policy  (st_reg.policy),
    .dout    (tx_word)
  );

  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  assign bus_tx_valid = st_reg.tx_valid;
  assign bus_tx_data  = st_reg.tx_valid ? tx_word : 32'h0000_0000;
  assign host_rx_data = st_reg.host_rx;
  assign link_enable  = st_reg.configured;
  assign status_base  = st_reg.stat_base;
  assign irq          = |(st_reg.irq_stat & st_reg.irq_en);

  always_comb begin
    status_word                   = 32'h0000_0000;
    status_word[ST_CONF_BIT]      = st_reg.configured;
    status_word[ST_ERR_BIT]       = st_reg.cfg_err;
    status_word[ST_HOST_BIT]      = st_reg.host_alive_d;
    status_word[ST_LINK_BIT]      = st_reg.configured && (st_reg.len != 11'h000);
    status_word[ST_RATE_LSB +: 2] = st_reg.rate;
  end

endmodule : gdl_top

// ---- sim/gdl_top_monitor.sv ----
/*
  Port checker for gdl_top: bus handshakes, link transmit and reset values.
  Assumes the one clock aclk and the synchronous active-low reset aresetn.
*/
`timescale 1ns/1ps
module gdl_top_monitor
  import gdl_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        scan_tick,
  input wire logic        bus_tx_valid,
  input wire logic [31:0] bus_tx_data,
  input wire logic [31:0] host_rx_data,
  input wire logic        link_enable,
  input wire logic [15:0] status_base
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_rst_values: assert property (
    $rose(aresetn) |-> !link_enable && !bus_tx_valid && status_base == 16'h0001)
    else $error("reset values wrong");
  chk_tx_cause: assert property (
    bus_tx_valid |-> $past(scan_tick)) else $error("tx without scan");
  chk_tx_idle_zero: assert property (
    !bus_tx_valid |-> bus_tx_data == 32'h0) else $error("tx data not zero");
  chk_rx_unconf: assert property (
    !link_enable [*3] |-> host_rx_data == 32'h0) else $error("rx data while unconfigured");
  chk_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response");
  chk_wr_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  chk_rd_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
  cov_write: cover property (s_axi_bvalid);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_tx: cover property (bus_tx_valid && bus_tx_data != 32'h0);
endmodule : gdl_top_monitor

bind gdl_top gdl_top_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scan_tick(scan_tick),
  .bus_tx_valid(bus_tx_valid), .bus_tx_data(bus_tx_data), .host_rx_data(host_rx_data),
  .link_enable(link_enable), .status_base(status_base));

// ---- sim/gdl_far_stations.sv ----
/*
  Model of the other stations on the field bus: scan requests, received
  words and the presence map. Driven by tasks called from the bench.
*/
`timescale 1ns/1ps
module gdl_far_stations (
  input  wire logic        aclk,
  output logic             scan_tick,
  output logic             rx_valid,
  output logic [4:0]       rx_station,
  output logic [31:0]      rx_data,
  output logic [31:0]      station_present
);
  // All stations share the device rate; the presence map starts with all 32 stations present
  initial begin
    scan_tick = 1'b0;
    rx_valid = 1'b0;
    rx_station = 5'h00;
    rx_data = 32'h0;
    station_present = 32'hffff_ffff;
  end
  task automatic tick();
    @(posedge aclk) scan_tick <= 1'b1;
    @(posedge aclk) scan_tick <= 1'b0;
  endtask : tick
  task automatic rx(input logic [4:0] st, input logic [31:0] d);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_station <= st;
    rx_data <= d;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask : rx
  // Station stops delivering
  task automatic drop(input logic [4:0] st);
    @(posedge aclk) station_present[st] <= 1'b0;
  endtask : drop
endmodule : gdl_far_stations

// ---- sim/tb.sv ----
/*
  Self-checking bench for gdl_top: register rows, then link cases.
  Assumes gdl_top_monitor is bound through its own file.
*/
`timescale 1ns/1ps
module tb
  import gdl_pkg::*;
;
  typedef struct { bit wr; logic [7:0] a; logic [31:0] d; logic [1:0] br; logic [31:0] rd;
                   logic [1:0] rr; } gdl_row_s;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, host_tx_data = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic host_alive = 1'b0, host_tx_load = 1'b0;
  logic [4:0] host_rx_station = 5'h05;
  logic awready, wready, bvalid, arready, rvalid, bus_tx_valid, link_enable, irq;
  logic scan_tick, rx_valid;
  logic [1:0] bresp, rresp, r;
  logic [4:0] rx_station;
  logic [31:0] rdata, rx_data, present, bus_tx_data, host_rx_data, status_word, v;
  logic [15:0] status_base;
  int err_count = 0, n_checks = 0;
  gdl_row_s rows[] = '{
    '{0, OFF_CTRL, 0, 0, 32'h10, RESP_OKAY},
    '{0, OFF_FAULT_ID, 0, 0, 32'h21, RESP_OKAY},
    '{0, OFF_LEGACY, 0, 0, 32'h0, RESP_OKAY},
    '{0, OFF_STATBASE, 0, 0, 32'h1, RESP_OKAY},
    '{0, OFF_MSG, 0, 0, 32'h1000, RESP_OKAY},
    '{1, OFF_FAULT_ID, 32'h10, RESP_OKAY, 32'h10, RESP_OKAY},
    '{1, OFF_FAULT_ID, 32'hfe, RESP_OKAY, 32'hfe, RESP_OKAY},
    '{1, OFF_FAULT_ID, 32'hff, RESP_SLVERR, 32'hfe, RESP_OKAY},
    '{1, OFF_FAULT_ID, 32'h0f, RESP_SLVERR, 32'hfe, RESP_OKAY},
    '{1, OFF_LEGACY, 32'h3fff, RESP_OKAY, 32'h3fff, RESP_OKAY},
    '{1, OFF_LEGACY, 32'h4000, RESP_SLVERR, 32'h3fff, RESP_OKAY},
    '{1, OFF_LEGACY, 32'h0, RESP_OKAY, 32'h0, RESP_OKAY},
    '{1, OFF_MSG, 32'h1040, RESP_OKAY, 32'h1040, RESP_OKAY},
    '{1, OFF_MSG, 32'h1041, RESP_SLVERR, 32'h1040, RESP_OKAY},
    '{1, OFF_MSG, 32'h400, RESP_OKAY, 32'h400, RESP_OKAY},
    '{1, OFF_MSG, 32'h800008, RESP_SLVERR, 32'h400, RESP_OKAY},
    '{1, OFF_MSG, 32'h800000, RESP_OKAY, 32'h800000, RESP_OKAY},
    '{1, OFF_CTRL, 32'h31f, RESP_SLVERR, 32'h10, RESP_OKAY},
    '{1, OFF_CTRL, 32'h30f, RESP_OKAY, 32'h30f, RESP_OKAY},
    '{1, OFF_CTRL, 32'h21f, RESP_OKAY, 32'h21f, RESP_OKAY},
    '{1, OFF_CTRL, 32'h11f, RESP_OKAY, 32'h11f, RESP_OKAY},
    '{1, OFF_CTRL, 32'h101f, RESP_OKAY, 32'h101f, RESP_OKAY},
    '{1, OFF_STATBASE, 32'h21, RESP_OKAY, 32'h21, RESP_OKAY},
    '{1, 8'h24, 32'h1, RESP_SLVERR, 32'h0, RESP_SLVERR}};
  always #4 aclk = ~aclk;
  gdl_far_stations i_far (.aclk(aclk), .scan_tick(scan_tick), .rx_valid(rx_valid),
    .rx_station(rx_station), .rx_data(rx_data), .station_present(present));
  gdl_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .host_alive(host_alive), .host_tx_load(host_tx_load), .host_tx_data(host_tx_data),
    .scan_tick(scan_tick), .bus_tx_valid(bus_tx_valid), .bus_tx_data(bus_tx_data),
    .rx_valid(rx_valid), .rx_station(rx_station), .rx_data(rx_data),
    .station_present(present), .host_rx_station(host_rx_station),
    .host_rx_data(host_rx_data), .link_enable(link_enable), .status_word(status_word),
    .status_base(status_base), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_done = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_done = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic load_tick(input logic [31:0] d, input logic alive);
    @(posedge aclk);
    host_tx_load <= 1'b1;
    host_tx_data <= d;
    host_alive <= alive;
    @(posedge aclk);
    host_tx_load <= 1'b0;
    repeat (3) @(posedge aclk);
    i_far.tick();
    #1;
  endtask : load_tick
  task automatic summarize();
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(status_base, 32'h1);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d, r);
        chk(r, rows[i].br);
      end
      rd(rows[i].a, v, r);
      chk(v, rows[i].rd);
      chk(r, rows[i].rr);
    end
    load_tick(32'ha5a5_0001, 1'b1);
    chk(bus_tx_valid, 32'h0);
    wr(OFF_MSG, 32'h1002, r);
    wr(OFF_CTRL, 32'h8000_0010, r);
    repeat (2) @(posedge aclk);
    #1;
    chk(link_enable, 32'h1);
    chk(status_word[ST_CONF_BIT], 32'h1);
    chk(status_base, 32'h21);
    load_tick(32'ha5a5_0001, 1'b1);
    chk(bus_tx_valid, 32'h1);
    chk(bus_tx_data, 32'ha5a5_0001);
    wr(OFF_IRQ_EN, 32'h0, r);
    load_tick(32'h0000_7777, 1'b0);
    chk(bus_tx_data, 32'h0);
    chk(irq, 32'h0);
    rd(OFF_IRQ_STAT, v, r);
    chk(v & 32'h3, 32'h3);
    wr(OFF_IRQ_EN, 32'h2, r);
    #1;
    chk(irq, 32'h1);
    wr(OFF_IRQ_CLR, 32'h2, r);
    #1;
    chk(irq, 32'h0);
    wr(OFF_CTRL, 32'h8000_1010, r);
    load_tick(32'h1234_5678, 1'b1);
    load_tick(32'h0bad_0bad, 1'b0);
    chk(bus_tx_data, 32'h1234_5678);
    i_far.rx(5'h05, 32'hdead_0005);
    repeat (3) @(posedge aclk);
    #1;
    chk(host_rx_data, 32'hdead_0005);
    i_far.drop(5'h05);
    repeat (3) @(posedge aclk);
    #1;
    chk(host_rx_data, 32'hdead_0005);
    wr(OFF_CTRL, 32'h8000_0010, r);
    repeat (3) @(posedge aclk);
    #1;
    chk(host_rx_data, 32'h0);
    summarize();
  end
endmodule : tb
